// File: design/bmc_pkg.sv
// Package: register map, field positions, reset values and timing for the mode control bank
`default_nettype none
package bmc_pkg;
  // APB byte addresses
  localparam logic [11:0] BMC_ADDR_CTRL   = 12'h000;  // basic_mode_control
  localparam logic [11:0] BMC_ADDR_STATUS = 12'h004;  // effective mode status
  // basic_mode_control field positions
  localparam int BMC_BIT_RESET    = 15;
  localparam int BMC_BIT_LOOPBACK = 14;
  localparam int BMC_BIT_SPEED    = 13;
  localparam int BMC_BIT_ANEG     = 12;
  localparam int BMC_BIT_PWRDN    = 11;
  localparam int BMC_BIT_ISOLATE  = 10;
  localparam int BMC_BIT_DUPLEX   = 8;
  // Status register field positions
  localparam int BMC_ST_SPEED100  = 0;
  localparam int BMC_ST_FULLDUP   = 1;
  localparam int BMC_ST_PWRDN     = 2;
  localparam int BMC_ST_ISOLATE   = 3;
  localparam int BMC_ST_LOOPBACK  = 4;
  localparam int BMC_ST_ANEG      = 5;
  localparam int BMC_ST_RESETTING = 6;
  // Software reset duration and loopback dead time
  localparam int BMC_CLK_MHZ          = 50;
  localparam int BMC_SWRST_NS         = 200;
  localparam int BMC_SWRST_CYC        = (BMC_SWRST_NS * BMC_CLK_MHZ + 999) / 1000;
  localparam int BMC_LPBK_DEAD_US     = 500;
  localparam int BMC_LPBK_DEAD_CYC    = BMC_LPBK_DEAD_US * BMC_CLK_MHZ;
  localparam logic [7:0] BMC_SWRST_LAST = 8'(BMC_SWRST_CYC - 1);
  localparam logic [7:0] BMC_CNT_RST    = 8'h00;
  localparam logic [31:0] BMC_RDATA_RST = 32'h0000_0000;
endpackage
`default_nettype wire

// File: design/bmc_ctrl.sv
// Basic mode control register bank (bits 15..10, 8) with APB slave
`default_nettype none
module bmc_ctrl
  import bmc_pkg::*;
(
  input  wire logic        clk,               // 50 MHz clock
  input  wire logic        rst,               // Async reset, active high
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB enable
  input  wire logic        pwrite,            // APB direction
  input  wire logic [11:0] paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic             pready,            // APB ready
  output logic      [31:0] prdata,            // APB read data
  output logic             pslverr,           // APB error
  input  wire logic        strap_aneg,        // Strap: aneg enable
  input  wire logic        strap_speed100,    // Strap: speed 100
  input  wire logic        strap_duplex,      // Strap: full duplex
  input  wire logic        fiber_mode_select, // Fiber mode enable
  input  wire logic        powerdown_pin_n,   // Power down pin, active low
  output logic             core_reset,        // Resets PHY core
  output logic             mii_loopback,      // Loop MII tx to rx
  output logic             speed_100,         // Effective speed 100 Mb/s
  output logic             full_duplex,       // Effective duplex
  output logic             aneg_active,       // Auto-negotiation on
  output logic             power_down,        // PHY power down
  output logic             mii_isolate        // MII isolated
);

  typedef struct packed {
    logic        swrst;
    logic [7:0]  cnt;
    logic        loadstrap;
    logic        lpbk;
    logic        speed;
    logic        aneg;
    logic        pwrdn;
    logic        iso;
    logic        duplex;
    logic        ready;
    logic [31:0] rdata;
    logic        err;
    logic        o_rst;
    logic        o_lpbk;
    logic        o_spd;
    logic        o_dup;
    logic        o_aneg;
    logic        o_pd;
    logic        o_iso;
  } bmc_state_t;

  bmc_state_t s_q, s_d;
  logic       acc;
  logic [15:0] ctrl_rd;
  logic [31:0] stat_rd;
  logic        eff_spd, eff_dup, eff_pd;

  assign acc = psel && penable && !s_q.ready;

  always_comb begin
    // Aneg on: forced speed and duplex bits are ignored
    eff_spd = s_q.aneg ? strap_speed100 : s_q.speed;
    eff_dup = s_q.aneg ? strap_duplex   : s_q.duplex;
    eff_pd  = s_q.pwrdn || !powerdown_pin_n;
    ctrl_rd = 16'h0000;
    ctrl_rd[BMC_BIT_RESET]    = s_q.swrst;
    ctrl_rd[BMC_BIT_LOOPBACK] = s_q.lpbk;
    ctrl_rd[BMC_BIT_SPEED]    = s_q.speed;
    ctrl_rd[BMC_BIT_ANEG]     = s_q.aneg;
    ctrl_rd[BMC_BIT_PWRDN]    = s_q.pwrdn;
    ctrl_rd[BMC_BIT_ISOLATE]  = s_q.iso;
    ctrl_rd[BMC_BIT_DUPLEX]   = s_q.duplex;
    stat_rd = 32'h0000_0000;
    stat_rd[BMC_ST_SPEED100]  = eff_spd;
    stat_rd[BMC_ST_FULLDUP]   = eff_dup;
    stat_rd[BMC_ST_PWRDN]     = eff_pd;
    stat_rd[BMC_ST_ISOLATE]   = s_q.iso;
    stat_rd[BMC_ST_LOOPBACK]  = s_q.lpbk;
    stat_rd[BMC_ST_ANEG]      = s_q.aneg;
    stat_rd[BMC_ST_RESETTING] = s_q.swrst;

    s_d = s_q;
    s_d.ready = acc;
    s_d.err   = 1'b0;
    s_d.rdata = BMC_RDATA_RST;
    s_d.loadstrap = 1'b0;
    // Reset sequence: hold core, then reload straps and clear on end
    // Runs before the bus decode so a restart write wins over the end
    if (s_q.swrst) begin
      if (s_q.cnt == BMC_SWRST_LAST) begin
        s_d.swrst     = 1'b0;
        s_d.loadstrap = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
    end
    if (acc) begin
      if (paddr == BMC_ADDR_CTRL) begin
        if (pwrite) begin
          s_d.lpbk   = pwdata[BMC_BIT_LOOPBACK];
          s_d.speed  = pwdata[BMC_BIT_SPEED];
          s_d.aneg   = pwdata[BMC_BIT_ANEG];
          s_d.pwrdn  = pwdata[BMC_BIT_PWRDN];
          s_d.iso    = pwdata[BMC_BIT_ISOLATE];
          s_d.duplex = pwdata[BMC_BIT_DUPLEX];
          if (pwdata[BMC_BIT_RESET]) begin
            s_d.swrst = 1'b1;
            s_d.cnt   = BMC_CNT_RST;
          end
        end else begin
          s_d.rdata = {16'h0000, ctrl_rd};
        end
      end else if (paddr == BMC_ADDR_STATUS) begin
        if (!pwrite) begin
          s_d.rdata = stat_rd;
        end
      end else begin
        s_d.err = 1'b1;
      end
    end
    if (s_q.loadstrap) begin
      s_d.lpbk   = 1'b0;
      s_d.pwrdn  = 1'b0;
      s_d.iso    = 1'b0;
      s_d.speed  = strap_speed100;
      s_d.duplex = strap_duplex;
      s_d.aneg   = strap_aneg && !fiber_mode_select;
    end
    // Pin assertion sets the bit; wins over a software clear
    if (!powerdown_pin_n) begin
      s_d.pwrdn = 1'b1;
    end
    s_d.o_rst  = s_d.swrst || s_d.loadstrap;
    s_d.o_lpbk = s_d.lpbk;
    s_d.o_aneg = s_d.aneg;
    s_d.o_spd  = s_d.aneg ? strap_speed100 : s_d.speed;
    s_d.o_dup  = s_d.aneg ? strap_duplex : s_d.duplex;
    s_d.o_pd   = s_d.pwrdn || !powerdown_pin_n;
    s_d.o_iso  = s_d.iso;
  end

  // Hardware reset loads straps through the same path one cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.loadstrap <= 1'b1;
      s_q.o_rst <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready       = s_q.ready;
  assign prdata       = s_q.rdata;
  assign pslverr      = s_q.err;
  assign core_reset   = s_q.o_rst;
  assign mii_loopback = s_q.o_lpbk;
  assign speed_100    = s_q.o_spd;
  assign full_duplex  = s_q.o_dup;
  assign aneg_active  = s_q.o_aneg;
  assign power_down   = s_q.o_pd;
  assign mii_isolate  = s_q.o_iso;

  property p_swrst_done;
    @(posedge clk) disable iff (rst)
    $rose(s_q.swrst) |-> ##9 s_q.swrst;
  endproperty
  a_swrst_done: assert property (p_swrst_done) else $error("soft reset length wrong");

  property p_strap_reload;
    @(posedge clk) disable iff (rst)
    s_q.loadstrap |=> s_q.aneg == ($past(strap_aneg) && !$past(fiber_mode_select));
  endproperty
  a_strap_reload: assert property (p_strap_reload) else $error("strap reload wrong");

  property p_fiber_aneg;
    @(posedge clk) disable iff (rst)
    s_q.loadstrap && fiber_mode_select |=> !s_q.aneg;
  endproperty
  a_fiber_aneg: assert property (p_fiber_aneg) else $error("fiber left aneg on");

  property p_lpbk_out;
    @(posedge clk) disable iff (rst)
    acc && pwrite && paddr == BMC_ADDR_CTRL && !s_q.loadstrap
      |=> mii_loopback == $past(pwdata[BMC_BIT_LOOPBACK]);
  endproperty
  a_lpbk_out: assert property (p_lpbk_out) else $error("loopback output wrong");

  property p_speed;
    @(posedge clk) disable iff (rst)
    !s_q.aneg && $stable(s_q.aneg) |-> speed_100 == s_q.speed;
  endproperty
  a_speed: assert property (p_speed) else $error("forced speed wrong");

  property p_aneg_ignore;
    @(posedge clk) disable iff (rst)
    s_q.aneg && $stable(s_q.aneg) && $stable(strap_duplex) |-> full_duplex == $past(strap_duplex);
  endproperty
  a_aneg_ignore: assert property (p_aneg_ignore) else $error("duplex not ignored");

  property p_pin_sets;
    @(posedge clk) disable iff (rst)
    !powerdown_pin_n |=> s_q.pwrdn && power_down;
  endproperty
  a_pin_sets: assert property (p_pin_sets) else $error("pin did not power down");

  property p_iso;
    @(posedge clk) disable iff (rst)
    acc && pwrite && paddr == BMC_ADDR_CTRL && !s_q.loadstrap
      |=> mii_isolate == $past(pwdata[BMC_BIT_ISOLATE]);
  endproperty
  a_iso: assert property (p_iso) else $error("isolate not applied");

  property p_clear13;
    @(posedge clk) disable iff (rst)
    s_q.loadstrap |=> !s_q.lpbk && !s_q.iso;
  endproperty
  a_clear13: assert property (p_clear13) else $error("reset left bits set");

  property p_swrst_end;
    @(posedge clk) disable iff (rst)
    s_q.swrst && s_q.cnt == BMC_SWRST_LAST && !acc |=> !s_q.swrst && s_q.loadstrap;
  endproperty
  a_swrst_end: assert property (p_swrst_end) else $error("soft reset did not end");

  property p_swrst_start;
    @(posedge clk) disable iff (rst)
    acc && pwrite && paddr == BMC_ADDR_CTRL && pwdata[BMC_BIT_RESET] |=> s_q.swrst;
  endproperty
  a_swrst_start: assert property (p_swrst_start) else $error("soft reset not started");

  property p_swrst_reads;
    @(posedge clk) disable iff (rst)
    acc && !pwrite && paddr == BMC_ADDR_CTRL && s_q.swrst |=> prdata[BMC_BIT_RESET];
  endproperty
  a_swrst_reads: assert property (p_swrst_reads) else $error("reset bit read as zero");

  property p_core_rst;
    @(posedge clk) disable iff (rst)
    s_q.swrst |=> core_reset;
  endproperty
  a_core_rst: assert property (p_core_rst) else $error("core not held in reset");

  property p_speed_strap;
    @(posedge clk) disable iff (rst)
    s_q.loadstrap |=> s_q.speed == $past(strap_speed100);
  endproperty
  a_speed_strap: assert property (p_speed_strap) else $error("speed strap not loaded");

  property p_dup_strap;
    @(posedge clk) disable iff (rst)
    s_q.loadstrap |=> s_q.duplex == $past(strap_duplex);
  endproperty
  a_dup_strap: assert property (p_dup_strap) else $error("duplex strap not loaded");

  property p_aneg_speed;
    @(posedge clk) disable iff (rst)
    s_q.aneg && $stable(s_q.aneg) |-> speed_100 == $past(strap_speed100);
  endproperty
  a_aneg_speed: assert property (p_aneg_speed) else $error("speed bit not ignored");

  property p_forced_dup;
    @(posedge clk) disable iff (rst)
    !s_q.aneg && $stable(s_q.aneg) |-> full_duplex == s_q.duplex;
  endproperty
  a_forced_dup: assert property (p_forced_dup) else $error("forced duplex wrong");

  property p_pwrdn_write;
    @(posedge clk) disable iff (rst)
    acc && pwrite && paddr == BMC_ADDR_CTRL && pwdata[BMC_BIT_PWRDN] && !s_q.loadstrap
      |=> power_down;
  endproperty
  a_pwrdn_write: assert property (p_pwrdn_write) else $error("power down bit ignored");

  property p_bus_alive;
    @(posedge clk) disable iff (rst)
    acc && power_down |=> pready;
  endproperty
  a_bus_alive: assert property (p_bus_alive) else $error("bus dead in power down");

  property p_pwrdn_clear;
    @(posedge clk) disable iff (rst)
    s_q.loadstrap && powerdown_pin_n |=> !s_q.pwrdn;
  endproperty
  a_pwrdn_clear: assert property (p_pwrdn_clear) else $error("power down not cleared");

  c_swrst: cover property (@(posedge clk) disable iff (rst) $fell(s_q.swrst));
  c_lpbk:  cover property (@(posedge clk) disable iff (rst) $rose(mii_loopback));
  c_pin:   cover property (@(posedge clk) disable iff (rst) $fell(powerdown_pin_n));
  c_err:   cover property (@(posedge clk) disable iff (rst) pslverr);
  c_fiber: cover property (@(posedge clk) disable iff (rst) s_q.loadstrap && fiber_mode_select);

endmodule
`default_nettype wire

// File: verification/bmc_mgmt_host.sv
// Management controller model: APB master for the mode control bank
`default_nettype none
module bmc_mgmt_host (
  input  wire logic        clk,     // Bus clock
  output logic             psel,    // Select
  output logic             penable, // Enable
  output logic             pwrite,  // Direction
  output logic      [11:0] paddr,   // Byte address
  output logic      [31:0] pwdata,  // Write data
  input  wire logic        pready,  // Ready
  input  wire logic [31:0] prdata,  // Read data
  input  wire logic        pslverr  // Error
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // Loopback receive data is not watched, so its dead time never matters
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show inverted values so stale data is never reused
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// File: verification/tb_phy_basic_mode_control.sv
// Testbench for the mode control bank
`default_nettype none
module tb_phy_basic_mode_control
  import bmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] wr; logic [31:0] ctrl; logic [31:0] st;} bmc_row_t;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        s_an, s_sp, s_dup, fiber, pin_n;
  logic        core_reset, lpbk, sp100, fdup, aneg, pdn, iso;
  int          err_count, num_checks;
  bmc_row_t    rows[6] = '{'{32'h0000_0000, 32'h0000_0000, 32'h0000_0000},
                           '{32'h0000_2100, 32'h0000_2100, 32'h0000_0003},
                           '{32'h0000_1000, 32'h0000_1000, 32'h0000_0021},
                           '{32'h0000_4000, 32'h0000_4000, 32'h0000_0010},
                           '{32'h0000_0800, 32'h0000_0800, 32'h0000_0004},
                           '{32'h0000_0400, 32'h0000_0400, 32'h0000_0008}};
  bmc_mgmt_host i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  bmc_ctrl i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .strap_aneg(s_an), .strap_speed100(s_sp), .strap_duplex(s_dup),
    .fiber_mode_select(fiber), .powerdown_pin_n(pin_n), .core_reset(core_reset),
    .mii_loopback(lpbk), .speed_100(sp100), .full_duplex(fdup), .aneg_active(aneg),
    .power_down(pdn), .mii_isolate(iso));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic print_verdict();
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    i_host.xfer(1'b0, a, 32'h0000_0000, rd, err);
    check({31'h0, err}, 32'h0000_0000);
    check(rd, exp);
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    s_an = 1'b1;
    s_sp = 1'b1;
    s_dup = 1'b0;
    fiber = 1'b0;
    pin_n = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rdchk(BMC_ADDR_CTRL, 32'h0000_3000);
    rdchk(BMC_ADDR_STATUS, 32'h0000_0021);
    foreach (rows[i]) begin
      wr(BMC_ADDR_CTRL, rows[i].wr);
      rdchk(BMC_ADDR_CTRL, rows[i].ctrl);
      rdchk(BMC_ADDR_STATUS, rows[i].st);
      check({26'h0, aneg, lpbk, iso, pdn, fdup, sp100}, rows[i].st);
    end
    // Pin low must beat a software clear of the power down bit
    pin_n <= 1'b0;
    wr(BMC_ADDR_CTRL, 32'h0000_0000);
    rdchk(BMC_ADDR_CTRL, 32'h0000_0800);
    check({31'h0, pdn}, 32'h0000_0001);
    pin_n <= 1'b1;
    wr(BMC_ADDR_CTRL, 32'h0000_0000);
    rdchk(BMC_ADDR_CTRL, 32'h0000_0000);
    i_host.xfer(1'b1, 12'h008, 32'h0000_ffff, rd, err);
    check({31'h0, err}, 32'h0000_0001);
    wr(BMC_ADDR_STATUS, 32'h0000_ffff);
    rdchk(BMC_ADDR_CTRL, 32'h0000_0000);
    fiber <= 1'b1;
    wr(BMC_ADDR_CTRL, 32'h0000_cc00);
    i_host.xfer(1'b0, BMC_ADDR_CTRL, 32'h0000_0000, rd, err);
    check(rd & 32'h0000_8000, 32'h0000_8000);
    check({31'h0, core_reset}, 32'h0000_0001);
    for (int n = 0; n < 40 && core_reset !== 1'b0; n++) @(posedge clk);
    check({31'h0, core_reset}, 32'h0000_0000);
    rdchk(BMC_ADDR_CTRL, 32'h0000_2000);
    rdchk(BMC_ADDR_STATUS, 32'h0000_0001);
    // Mid-run hardware reset: new straps, bits 14, 11, 10 cleared
    fiber <= 1'b0;
    s_sp <= 1'b0;
    s_dup <= 1'b1;
    wr(BMC_ADDR_CTRL, 32'h0000_4c00);
    rst <= 1'b1;
    @(posedge clk);
    check({31'h0, core_reset}, 32'h0000_0001);
    check({26'h0, aneg, lpbk, iso, pdn, fdup, sp100}, 32'h0000_0000);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rdchk(BMC_ADDR_CTRL, 32'h0000_1100);
    rdchk(BMC_ADDR_STATUS, 32'h0000_0022);
    check({26'h0, aneg, lpbk, iso, pdn, fdup, sp100}, 32'h0000_0022);
    print_verdict();
  end
endmodule
`default_nettype wire
